// ==== logic/hbr_pkg.sv ====
// Shared constants and types for the host bus response block.
package hbr_pkg;

	// Width of the request command lines.
	localparam int unsigned HBR_CMD_W = 5;
	// Width of the response status lines.
	localparam int unsigned HBR_RS_W = 3;

	// Response status codes, logical value (a one means the active-low line is low).
	localparam logic [2:0] HBR_RS_IDLE = 3'h0;
	localparam logic [2:0] HBR_RS_RETRY = 3'h1;
	localparam logic [2:0] HBR_RS_NO_DATA = 3'h5;
	localparam logic [2:0] HBR_RS_IMPL_WB = 3'h6;
	localparam logic [2:0] HBR_RS_NORMAL = 3'h7;

	// Response kinds that the core logic may ask for.
	typedef enum logic [1:0] {
		HBR_KIND_NORMAL = 2'h0,
		HBR_KIND_NO_DATA = 2'h1,
		HBR_KIND_RETRY = 2'h2,
		HBR_KIND_IMPL_WB = 2'h3
	} hbr_kind_t;

	// Transaction tracker states.
	typedef enum logic [2:0] {
		HBR_ST_IDLE = 3'h0,
		HBR_ST_REQ_B = 3'h1,
		HBR_ST_WAIT = 3'h2,
		HBR_ST_TARGET = 3'h3,
		HBR_ST_DATA = 3'h4,
		HBR_ST_RESP = 3'h5
	} hbr_state_t;

	// Maps a response kind onto its status code; reserved codes cannot come out.
	function automatic logic [2:0] hbr_code(input hbr_kind_t kind);
		case (kind)
			HBR_KIND_NORMAL: hbr_code = HBR_RS_NORMAL;
			HBR_KIND_NO_DATA: hbr_code = HBR_RS_NO_DATA;
			HBR_KIND_RETRY: hbr_code = HBR_RS_RETRY;
			HBR_KIND_IMPL_WB: hbr_code = HBR_RS_IMPL_WB;
			default: hbr_code = HBR_RS_NO_DATA;
		endcase
	endfunction

endpackage

// ==== logic/hbr_resp_drive.sv ====
// Registered driver for the response status, parity and retry lines.
`timescale 1ns/10ps
module hbr_resp_drive (
	// Clock and reset.
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	// Code to place on the bus next cycle; idle means release.
	input wire logic [2:0] next_code_in,
	// Bus side.
	output logic [2:0] response_status_n_out,
	output logic response_status_oe_out,
	output logic response_parity_n_out,
	output logic response_parity_oe_out,
	output logic defer_n_out,
	output logic defer_oe_out
);

	// Parity level for the code: high when an even number of lines are low.
	logic next_parity;

	// [R02] Even low count
	assign next_parity = ~(^next_code_in);

	// Status, parity and enables all load on the same edge so they never skew.
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			response_status_n_out <= ~hbr_pkg::HBR_RS_IDLE;
			response_status_oe_out <= 1'b0;
			response_parity_n_out <= 1'b1;
			response_parity_oe_out <= 1'b0;
		end else begin
			// [R16] Parity registered with status
			response_status_n_out <= ~next_code_in;
			response_parity_n_out <= next_parity;
			// [R01] Parity driven with status
			response_status_oe_out <= (next_code_in != hbr_pkg::HBR_RS_IDLE);
			// [R03] Idle leaves parity undriven
			response_parity_oe_out <= (next_code_in != hbr_pkg::HBR_RS_IDLE);
		end
	end

	// The retry indication rides alongside a retry status.
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			defer_n_out <= 1'b1;
			defer_oe_out <= 1'b0;
		end else begin
			// [R11] Defer signals retry
			defer_n_out <= (next_code_in != hbr_pkg::HBR_RS_RETRY);
			defer_oe_out <= (next_code_in == hbr_pkg::HBR_RS_RETRY);
		end
	end

endmodule

// ==== logic/hbr_host_bus.sv ====
// System-logic end of the host bus: request capture, snoop, target ready and response.
//
// Functional notes
// [R01] Parity driven whenever status is driven.
// [R02] Parity high for even count of lows.
// [R03] Idle status leaves parity undriven, high.
// [R04] Target ready only when data accepted.
// [R05] Address strobe marks a new cycle.
// [R06] Command sampled in strobe clock and next.
// [R07] Bus request asserted while ownership wanted.
// [R08] Block-next-request holds off new requests.
// [R09] Lock marks an atomic sequence.
// [R10] Hit-modified reports a modified line.
// [R11] Defer output signals a retry response.
// [R12] Status codes: idle, retry, nodata, writeback, normal.
// [R13] Reserved status codes are never driven.
// [R14] Data-ready marks valid data clocks.
// [R15] Data-busy holds the bus without data.
// [R16] Parity computed and registered with status.
// [R17] Everything on host clock, cleared by reset.
`timescale 1ns/10ps
module hbr_host_bus (
	// Host clock and host bus reset.
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	// Request phase from the bus owner.
	input wire logic address_strobe_n_in,
	input wire logic [4:0] request_command_n_in,
	input wire logic host_locked_cycle_n_in,
	// Snoop result from the processor.
	input wire logic snoop_hit_modified_n_in,
	// Data phase handshakes from the bus owner.
	input wire logic data_valid_n_in,
	input wire logic data_bus_held_n_in,
	// Block-next-request, a shared two-way line.
	input wire logic block_next_request_n_in,
	output logic block_next_request_n_out,
	output logic block_next_request_oe_out,
	// Target ready, two-way.
	output logic target_ready_n_out,
	output logic target_ready_oe_out,
	// Response status, parity and retry lines.
	output logic [2:0] response_status_n_out,
	output logic response_status_oe_out,
	output logic response_parity_n_out,
	output logic response_parity_oe_out,
	output logic defer_n_out,
	output logic defer_oe_out,
	// Symmetric bus request.
	output logic symmetric_bus_request_n_out,
	// Core side: bus ownership.
	input wire logic want_bus_in,
	output logic request_allowed_out,
	// Core side: captured request.
	output logic req_valid_out,
	output logic [4:0] req_cmd_a_out,
	output logic [4:0] req_cmd_b_out,
	output logic req_locked_out,
	output logic req_hit_modified_out,
	output logic locked_seq_out,
	// Core side: response request.
	input wire logic resp_valid_in,
	input wire logic [1:0] resp_kind_in,
	input wire logic resp_write_in,
	input wire logic accept_data_in,
	output logic resp_ready_out,
	output logic write_data_out,
	output logic resp_done_out,
	// Core side: extra blocking request.
	input wire logic block_in
);

	// Tracker state, registered.
	hbr_pkg::hbr_state_t state;
	// Tracker state for the coming cycle.
	hbr_pkg::hbr_state_t next_state;
	// Response kind taken at the core handshake.
	hbr_pkg::hbr_kind_t kind;
	// Status code that the line driver places on the bus in the next cycle.
	logic [2:0] next_code;
	// Whether the block-next-request line is pulled low in the next cycle.
	logic next_block;
	// A new request starts: strobe seen while nothing is in flight.
	logic strobe_seen;
	// The core hands over a response in this cycle.
	logic resp_taken;
	// A write data clock is taken in this cycle.
	logic data_taken;

	// Only one transaction is tracked, so a strobe is honoured only when idle.
	// [R05] Strobe starts cycle
	assign strobe_seen = (state == hbr_pkg::HBR_ST_IDLE) && !address_strobe_n_in;

	// The core may hand over a response only while the tracker waits for one.
	assign resp_ready_out = (state == hbr_pkg::HBR_ST_WAIT);
	assign resp_taken = resp_ready_out && resp_valid_in;

	// A data clock counts when the owner marks valid data on the bus.
	// [R14] Data-ready marks data
	assign data_taken = ((state == hbr_pkg::HBR_ST_TARGET) && accept_data_in &&
		!data_valid_n_in) || ((state == hbr_pkg::HBR_ST_DATA) && !data_valid_n_in);

	// Requests may start only while nobody blocks the pipeline.
	// [R08] Hold off requests
	assign request_allowed_out = block_next_request_n_in;

	// Target ready is driven through the whole target phase, low only while the
	// core can take the data, so the owner never sends data that would be lost.
	// [R04] Ready only when accepting
	assign target_ready_oe_out = (state == hbr_pkg::HBR_ST_TARGET);
	assign target_ready_n_out = !((state == hbr_pkg::HBR_ST_TARGET) && accept_data_in);

	// Next state of the transaction tracker.
	always_comb begin
		next_state = state;
		case (state)
			// Wait for a strobe from the bus owner.
			hbr_pkg::HBR_ST_IDLE: begin
				if (strobe_seen) begin
					next_state = hbr_pkg::HBR_ST_REQ_B;
				end
			end
			// Second command clock, always exactly one cycle.
			hbr_pkg::HBR_ST_REQ_B: begin
				next_state = hbr_pkg::HBR_ST_WAIT;
			end
			// Wait for the core to choose a response.
			hbr_pkg::HBR_ST_WAIT: begin
				if (resp_taken) begin
					if (resp_write_in) begin
						next_state = hbr_pkg::HBR_ST_TARGET;
					end else begin
						next_state = hbr_pkg::HBR_ST_RESP;
					end
				end
			end
			// Target ready phase: first data clock ends it.
			hbr_pkg::HBR_ST_TARGET: begin
				if (data_taken) begin
					if (data_bus_held_n_in) begin
						next_state = hbr_pkg::HBR_ST_RESP;
					end else begin
						next_state = hbr_pkg::HBR_ST_DATA;
					end
				end
			end
			// The owner keeps the data bus; the last data clock releases it.
			// [R15] Data-busy holds bus
			hbr_pkg::HBR_ST_DATA: begin
				if (!data_valid_n_in && data_bus_held_n_in) begin
					next_state = hbr_pkg::HBR_ST_RESP;
				end
			end
			// One cycle in which the response code is handed to the driver.
			hbr_pkg::HBR_ST_RESP: begin
				next_state = hbr_pkg::HBR_ST_IDLE;
			end
			// Unused codes fall back to idle.
			default: begin
				next_state = hbr_pkg::HBR_ST_IDLE;
			end
		endcase
	end

	// Tracker state register.
	// [R17] Host clock, reset
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			state <= hbr_pkg::HBR_ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Request capture: the command stands for two clocks and is taken in both.
	// [R06] Command in both clocks
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			req_cmd_a_out <= 5'h00;
			req_cmd_b_out <= 5'h00;
			req_locked_out <= 1'b0;
			req_hit_modified_out <= 1'b0;
			req_valid_out <= 1'b0;
		end else begin
			// First command clock, with the strobe.
			if (strobe_seen) begin
				req_cmd_a_out <= ~request_command_n_in;
				req_locked_out <= !host_locked_cycle_n_in;
			end
			// Second command clock; the snoop result is taken here as well.
			if (state == hbr_pkg::HBR_ST_REQ_B) begin
				req_cmd_b_out <= ~request_command_n_in;
				req_hit_modified_out <= !snoop_hit_modified_n_in;
			end
			// The captured request is offered for one cycle.
			req_valid_out <= (state == hbr_pkg::HBR_ST_REQ_B);
		end
	end

	// Locked sequence flag: set or cleared by the lock level at each new strobe,
	// so the core sees the whole sequence and can keep it atomic.
	// [R09] Lock marks sequence
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			locked_seq_out <= 1'b0;
		end else if (strobe_seen) begin
			locked_seq_out <= !host_locked_cycle_n_in;
		end
	end

	// Response kind is latched at the handshake and used in the response cycle.
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			kind <= hbr_pkg::HBR_KIND_NO_DATA;
		end else if (resp_taken) begin
			kind <= hbr_pkg::hbr_kind_t'(resp_kind_in);
		end
	end

	// Core strobes: a write data clock taken, and the response placed on the bus.
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			write_data_out <= 1'b0;
			resp_done_out <= 1'b0;
		end else begin
			write_data_out <= data_taken;
			resp_done_out <= (state == hbr_pkg::HBR_ST_RESP);
		end
	end

	// Symmetric bus request follows the core's wish, one clock later.
	// [R07] Request while wanted
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			symmetric_bus_request_n_out <= 1'b1;
		end else begin
			symmetric_bus_request_n_out <= !want_bus_in;
		end
	end

	// The pipeline is blocked while a transaction is tracked or the core asks.
	// [R08] Block while busy
	assign next_block = block_in || (next_state != hbr_pkg::HBR_ST_IDLE);

	// Block-next-request line, driven only while it is pulled low.
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			block_next_request_n_out <= 1'b1;
			block_next_request_oe_out <= 1'b0;
		end else begin
			block_next_request_n_out <= !next_block;
			block_next_request_oe_out <= next_block;
		end
	end

	// Only the response cycle hands a code to the driver; otherwise idle.
	// [R12] Codes from kind
	// [R13] Reserved never produced
	assign next_code = (state == hbr_pkg::HBR_ST_RESP) ? hbr_pkg::hbr_code(kind) :
		hbr_pkg::HBR_RS_IDLE;

	// Status, parity and retry lines, all registered together.
	// [R01] Parity with status
	// [R11] Defer on retry
	hbr_resp_drive u_resp_drive (
		.sys_clk_in(sys_clk_in),
		.rstn_in(rstn_in),
		.next_code_in(next_code),
		.response_status_n_out(response_status_n_out),
		.response_status_oe_out(response_status_oe_out),
		.response_parity_n_out(response_parity_n_out),
		.response_parity_oe_out(response_parity_oe_out),
		.defer_n_out(defer_n_out),
		.defer_oe_out(defer_oe_out)
	);

endmodule

// ==== test/hbr_host_model.sv ====
// Bus owner model: strobe, command and lock.
`timescale 1ns/10ps
module hbr_host_model (
	// Clock and start request.
	input wire logic sys_clk_in,
	input wire logic go_in,
	input wire logic lock_in,
	input wire logic [4:0] cmd_in,
	// Request phase lines.
	output logic ads_n_out = 1'b1,
	output logic lock_n_out = 1'b1,
	output logic [4:0] cmd_n_out = 5'h1F
);
	// The strobe stands one clock, the command that clock and the next.
	// Strobe, command, lock
	always @(posedge sys_clk_in) begin
		ads_n_out <= !go_in;
		lock_n_out <= !(go_in && lock_in);
		cmd_n_out <= (go_in || !ads_n_out) ? ~cmd_in : 5'h1F;
	end
endmodule

// ==== test/hbr_host_bus_assertions.sv ====
// Checker for the host bus response lines.
`timescale 1ns/10ps
module hbr_host_bus_checker (
	// Clock, reset and watched ports.
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	input wire logic want_bus_in,
	input wire logic accept_data_in,
	input wire logic [2:0] response_status_n_out,
	input wire logic response_status_oe_out,
	input wire logic response_parity_n_out,
	input wire logic response_parity_oe_out,
	input wire logic defer_n_out,
	input wire logic target_ready_n_out,
	input wire logic target_ready_oe_out,
	input wire logic symmetric_bus_request_n_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rstn_in);
	wire logic oe = response_status_oe_out;
	wire logic [2:0] rs = ~response_status_n_out;
	property p_par; oe |-> response_parity_oe_out && (response_parity_n_out == ~(^rs)); endproperty
	a_par: assert property (p_par) else $error("bad parity");
	property p_idle; !oe |-> !response_parity_oe_out; endproperty
	a_idle: assert property (p_idle) else $error("parity driven");
	property p_code; oe |-> rs inside {3'h1, 3'h5, 3'h6, 3'h7}; endproperty
	a_code: assert property (p_code) else $error("bad code");
	property p_rsv; oe |-> !(rs inside {3'h4, 3'h2, 3'h3}); endproperty
	a_rsv: assert property (p_rsv) else $error("reserved code");
	property p_defer; !defer_n_out |-> oe && rs == 3'h1; endproperty
	a_defer: assert property (p_defer) else $error("bad defer");
	property p_breq; $rose(want_bus_in) |-> ##[0:2] !symmetric_bus_request_n_out; endproperty
	a_breq: assert property (p_breq) else $error("no request");
	property p_target_ready_n; target_ready_oe_out && !target_ready_n_out |-> accept_data_in; endproperty
	a_target_ready_n: assert property (p_target_ready_n) else $error("bad ready");
	property p_rst; disable iff (1'b0) !rstn_in ##1 !rstn_in |-> !oe && !target_ready_oe_out;
	endproperty
	a_rst: assert property (p_rst) else $error("driven in reset");
	c_retry: cover property (oe && !defer_n_out);
	c_norm: cover property (oe && rs == 3'h7);
	c_breq: cover property (!symmetric_bus_request_n_out);
endmodule
bind hbr_host_bus hbr_host_bus_checker u_chk (.*);

// ==== test/host_bus_response_signaling_tb.sv ====
// Bench for the host bus response block.
`timescale 1ns/10ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin num_errors++; \
	$display("mismatch %0t %h %h", $time, a, e); end end
module host_bus_response_signaling_tb;
	// Result counters.
	int num_errors = 0;
	int total_checks = 0;
	// Clock, reset and core-side stimulus.
	logic sys_clk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic want_bus_in = 1'b0;
	logic resp_valid_in = 1'b0;
	logic resp_write_in = 1'b0;
	logic accept_data_in = 1'b1;
	logic block_in = 1'b0;
	logic [1:0] resp_kind_in = 2'h0;
	// Host model controls.
	logic go = 1'b0;
	logic lock = 1'b0;
	logic [4:0] cmd = 5'h0B;
	// Host lines driven straight by the bench.
	logic snoop_hit_modified_n_in = 1'b1;
	logic data_valid_n_in = 1'b1;
	logic data_bus_held_n_in = 1'b1;
	// Block outputs.
	wire logic [2:0] response_status_n_out;
	wire logic [4:0] request_command_n_in, req_cmd_a_out, req_cmd_b_out;
	wire logic block_next_request_n_out, block_next_request_oe_out, target_ready_n_out;
	wire logic target_ready_oe_out, response_status_oe_out, response_parity_n_out;
	wire logic response_parity_oe_out, defer_n_out, defer_oe_out, symmetric_bus_request_n_out;
	wire logic request_allowed_out, req_valid_out, req_locked_out, req_hit_modified_out;
	wire logic locked_seq_out, resp_ready_out, write_data_out, resp_done_out;
	wire logic address_strobe_n_in, host_locked_cycle_n_in;
	// The shared block line rests high through its pull-up when nobody drives it.
	wire logic block_next_request_n_in = block_next_request_oe_out ?
		block_next_request_n_out : 1'b1;

	hbr_host_bus dut (
		.sys_clk_in(sys_clk_in),
		.rstn_in(rstn_in),
		.address_strobe_n_in(address_strobe_n_in),
		.request_command_n_in(request_command_n_in),
		.host_locked_cycle_n_in(host_locked_cycle_n_in),
		.snoop_hit_modified_n_in(snoop_hit_modified_n_in),
		.data_valid_n_in(data_valid_n_in),
		.data_bus_held_n_in(data_bus_held_n_in),
		.block_next_request_n_in(block_next_request_n_in),
		.block_next_request_n_out(block_next_request_n_out),
		.block_next_request_oe_out(block_next_request_oe_out),
		.target_ready_n_out(target_ready_n_out),
		.target_ready_oe_out(target_ready_oe_out),
		.response_status_n_out(response_status_n_out),
		.response_status_oe_out(response_status_oe_out),
		.response_parity_n_out(response_parity_n_out),
		.response_parity_oe_out(response_parity_oe_out),
		.defer_n_out(defer_n_out),
		.defer_oe_out(defer_oe_out),
		.symmetric_bus_request_n_out(symmetric_bus_request_n_out),
		.want_bus_in(want_bus_in),
		.request_allowed_out(request_allowed_out),
		.req_valid_out(req_valid_out),
		.req_cmd_a_out(req_cmd_a_out),
		.req_cmd_b_out(req_cmd_b_out),
		.req_locked_out(req_locked_out),
		.req_hit_modified_out(req_hit_modified_out),
		.locked_seq_out(locked_seq_out),
		.resp_valid_in(resp_valid_in),
		.resp_kind_in(resp_kind_in),
		.resp_write_in(resp_write_in),
		.accept_data_in(accept_data_in),
		.resp_ready_out(resp_ready_out),
		.write_data_out(write_data_out),
		.resp_done_out(resp_done_out),
		.block_in(block_in)
	);

	hbr_host_model u_host (
		.sys_clk_in(sys_clk_in),
		.go_in(go),
		.lock_in(lock),
		.cmd_in(cmd),
		.ads_n_out(address_strobe_n_in),
		.lock_n_out(host_locked_cycle_n_in),
		.cmd_n_out(request_command_n_in)
	);

	// Issues one request through the host model and checks what was captured.
	task automatic issue_request(input logic [4:0] c, input logic lk, input logic hm);
		int n;
		n = 0;
		while (request_allowed_out !== 1'b1 && n < 50) begin
			@(negedge sys_clk_in);
			n++;
		end
		@(posedge sys_clk_in);
		cmd <= c;
		lock <= lk;
		go <= 1'b1;
		snoop_hit_modified_n_in <= !hm;
		@(posedge sys_clk_in);
		go <= 1'b0;
		n = 0;
		do begin
			@(negedge sys_clk_in);
			n++;
		end while (req_valid_out !== 1'b1 && n < 20);
		`CHK(req_valid_out, 1'b1)
		`CHK(req_cmd_a_out, c)
		`CHK(req_cmd_b_out, c)
		`CHK(req_locked_out, lk)
		`CHK(locked_seq_out, lk)
		`CHK(req_hit_modified_out, hm)
		`CHK(request_allowed_out, 1'b0)
		@(posedge sys_clk_in);
		snoop_hit_modified_n_in <= 1'b1;
	endtask

	// Hands a response to the block and holds it until the ready edge.
	task automatic handshake(input logic [1:0] k, input logic w);
		int n;
		@(posedge sys_clk_in);
		resp_kind_in <= k;
		resp_write_in <= w;
		resp_valid_in <= 1'b1;
		n = 0;
		do begin
			@(negedge sys_clk_in);
			n++;
		end while (resp_ready_out !== 1'b1 && n < 20);
		@(posedge sys_clk_in);
		resp_valid_in <= 1'b0;
		resp_write_in <= 1'b0;
	endtask

	// Waits for the one-cycle status and checks code, parity, retry and release.
	task automatic check_status(input logic [2:0] code);
		int n;
		n = 0;
		do begin
			@(negedge sys_clk_in);
			n++;
		end while (response_status_oe_out !== 1'b1 && n < 20);
		`CHK(~response_status_n_out, code)
		`CHK(response_parity_oe_out, 1'b1)
		`CHK(response_parity_n_out, ~^code)
		`CHK(defer_n_out, code != hbr_pkg::HBR_RS_RETRY)
		`CHK(defer_oe_out, code == hbr_pkg::HBR_RS_RETRY)
		`CHK(resp_done_out, 1'b1)
		@(negedge sys_clk_in);
		`CHK(response_status_oe_out, 1'b0)
		`CHK(response_parity_oe_out, 1'b0)
		`CHK(block_next_request_oe_out, 1'b0)
	endtask

	// Bus request follows the core's wish.
	task automatic test_breq;
		@(posedge sys_clk_in);
		want_bus_in <= 1'b1;
		repeat (2) @(posedge sys_clk_in);
		@(negedge sys_clk_in);
		`CHK(symmetric_bus_request_n_out, 1'b0)
		@(posedge sys_clk_in);
		want_bus_in <= 1'b0;
		repeat (2) @(posedge sys_clk_in);
		@(negedge sys_clk_in);
		`CHK(symmetric_bus_request_n_out, 1'b1)
		$display("test_breq done");
	endtask

	// Core blocking request pulls the shared line low and holds off requests.
	task automatic test_block;
		@(posedge sys_clk_in);
		block_in <= 1'b1;
		@(posedge sys_clk_in);
		@(negedge sys_clk_in);
		`CHK(block_next_request_n_out, 1'b0)
		`CHK(request_allowed_out, 1'b0)
		@(posedge sys_clk_in);
		block_in <= 1'b0;
		@(posedge sys_clk_in);
		@(negedge sys_clk_in);
		`CHK(request_allowed_out, 1'b1)
		$display("test_block done");
	endtask

	// Every response kind after a read request, locked and not, snoop hit and not.
	task automatic test_read_kinds;
		logic [2:0] e [4];
		e[0] = hbr_pkg::HBR_RS_NORMAL;
		e[1] = hbr_pkg::HBR_RS_NO_DATA;
		e[2] = hbr_pkg::HBR_RS_RETRY;
		e[3] = hbr_pkg::HBR_RS_IMPL_WB;
		for (int k = 0; k < 4; k++) begin
			issue_request(5'(5'h0B + k), k[0], !k[0]);
			handshake(2'(k), 1'b0);
			check_status(e[k]);
		end
		$display("test_read_kinds done");
	endtask

	// Write with a target phase, a held ready, and two data clocks, data-busy on the first only.
	task automatic test_write;
		int n;
		issue_request(5'h05, 1'b0, 1'b0);
		accept_data_in <= 1'b0;
		handshake(2'h1, 1'b1);
		@(negedge sys_clk_in);
		`CHK(target_ready_oe_out, 1'b1)
		`CHK(target_ready_n_out, 1'b1)
		@(posedge sys_clk_in);
		accept_data_in <= 1'b1;
		@(negedge sys_clk_in);
		`CHK(target_ready_n_out, 1'b0)
		@(posedge sys_clk_in);
		data_valid_n_in <= 1'b0;
		data_bus_held_n_in <= 1'b0;
		@(posedge sys_clk_in);
		data_bus_held_n_in <= 1'b1;
		@(negedge sys_clk_in);
		`CHK(write_data_out, 1'b1)
		`CHK(target_ready_oe_out, 1'b0)
		@(posedge sys_clk_in);
		data_valid_n_in <= 1'b1;
		@(negedge sys_clk_in);
		`CHK(write_data_out, 1'b1)
		n = 0;
		check_status(hbr_pkg::HBR_RS_NO_DATA);
		`CHK(write_data_out, 1'b0)
		$display("test_write done");
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic summarize;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	// Clock of 10 ns.
	initial forever #5 sys_clk_in = ~sys_clk_in;

	// Reset for 16 clocks, then the scenarios in turn.
	initial begin
		repeat (16) @(posedge sys_clk_in);
		rstn_in <= 1'b1;
		repeat (2) @(posedge sys_clk_in);
		test_breq;
		test_block;
		test_read_kinds;
		test_write;
		summarize;
	end

	// Watchdog: the scenarios need well under a thousand clocks.
	initial begin
		#20000;
		num_errors++;
		summarize;
	end
endmodule
